// >>> src/adc_sequencing_control.sv
// Sequencing, window compare, flags and register slave of the converter's digital side
//
// Summary of operation
// - Startup wait 0..256 converter cycles before sampling
// - Same startup wait after deep sleep wake
// - Auto variation increments delay field, wraps
// - Inter-sample delay equals delay field cycles
// - Sampling switch open during inter-sample delay
// - Window mode: none, below, above, inside, outside
// - Window compares full 16-bit accumulated result
// - Sampling lasts two cycles plus extension
// - Input select: inputs 0-15, reference, sensor, ground
// - Input change applies after running conversion
// - Writing start bit begins a measurement
// - Start bit reads one while converting
// - Event starts conversion when enabled
// - Interrupt request only when enable set
// - Window flag set at conversion end
// - Result-ready flag set per completed measurement
// - Flags clear by write one or result read
// - Debug halt freezes unless run bit set
// - One shared byte latch for word registers
// - Continuous mode restarts after each completion
// - Accumulate 1 to 64 samples per conversion
// - Converter clock divides peripheral clock 2..256
// - Word registers: write high byte then low byte, read low byte then high byte
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module adc_sequencing_control import adc_seq_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// System events
	input wire logic event_in,
	input wire logic debug_halt,
	input wire logic wake_measure,
	// Analog core
	output core_ctl_s core_ctl,
	input wire core_stat_s core_stat,
	// Interrupt request
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [8:0] startup_cycles(input logic [2:0] code);
		case (code)
			3'h1: startup_cycles = 9'h010;
			3'h2: startup_cycles = 9'h020;
			3'h3: startup_cycles = 9'h040;
			3'h4: startup_cycles = 9'h080;
			3'h5: startup_cycles = 9'h100;
			default: startup_cycles = 9'h000;
		endcase
	endfunction

	function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] res,
		input logic [15:0] lo, input logic [15:0] hi);
		case (mode)
			WIN_BELOW: window_hit = res < lo;
			WIN_ABOVE: window_hit = res > hi;
			WIN_INSIDE: window_hit = (res > lo) && (res < hi);
			WIN_OUTSIDE: window_hit = (res < lo) || (res > hi);
			default: window_hit = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic enable, continuous_mode;
	logic [1:0] refsel;
	logic [2:0] accumulation_count, clock_divider, startup_wait, window_mode_sel;
	logic delay_variation_en, event_start_en, run_in_debug, start_busy, need_init;
	logic [3:0] intersample_delay;
	logic [4:0] sample_extension, input_channel;
	logic [1:0] irq_enable, irq_flags;
	logic [7:0] byte_latch, div_cnt, wait_cnt;
	logic [15:0] conversion_result, low_threshold, high_threshold, accum;
	logic [5:0] samples_left;
	seq_state_e state;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	logic aw_full, w_full;
	logic [5:0] w_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire do_write = aw_full & w_full & ~bvalid;
	wire next_aw_full = aw_take | (aw_full & ~do_write);
	wire next_w_full = w_take | (w_full & ~do_write);
	wire ar_take = arvalid & arready;
	wire r_done = rvalid & rready;
	wire next_r_busy = ar_take | (rvalid & ~r_done);
	wire [5:0] r_idx = araddr[7:2];
	wire wr = do_write & w_lane0;

	function automatic logic idx_known(input logic [5:0] idx);
		idx_known = (idx <= `IDX_HIGH_THR_HI) && (idx != 6'h07) && (idx != 6'h0e) &&
			(idx != 6'h0f);
	endfunction

	wire wr_control = wr && w_idx == `IDX_CONTROL;
	wire wr_clock = wr && w_idx == `IDX_CLOCK;
	wire wr_timing = wr && w_idx == `IDX_TIMING;
	wire wr_start = wr && w_idx == `IDX_START;
	wire wr_flags = wr && w_idx == `IDX_FLAGS;
	wire wr_wake_ref = wr_clock && w_byte[`POS_REFSEL +: 2] == `REF_INTERNAL &&
		refsel != `REF_INTERNAL;
	wire rd_result = ar_take && (r_idx == `IDX_RESULT_LO || r_idx == `IDX_RESULT_HI);
	wire rd_low_word = ar_take && (r_idx == `IDX_RESULT_LO || r_idx == `IDX_LOW_THR_LO ||
		r_idx == `IDX_HIGH_THR_LO);

	logic [7:0] rd_byte, rd_high;
	always_comb begin
		rd_high = 8'h00;
		case (r_idx)
			`IDX_CONTROL: rd_byte = {2'h0, refsel, 2'h0, continuous_mode, enable};
			`IDX_ACCUM: rd_byte = {5'h00, accumulation_count};
			`IDX_CLOCK: rd_byte = {2'h0, refsel, 1'b0, clock_divider};
			`IDX_TIMING: rd_byte = {startup_wait, delay_variation_en, intersample_delay};
			`IDX_WINDOW: rd_byte = {5'h00, window_mode_sel};
			`IDX_SAMPLE_LEN: rd_byte = {3'h0, sample_extension};
			`IDX_INPUT_SEL: rd_byte = {3'h0, input_channel};
			`IDX_START: rd_byte = {7'h00, start_busy};
			`IDX_EVENT: rd_byte = {7'h00, event_start_en};
			`IDX_IRQ_EN: rd_byte = {6'h00, irq_enable};
			`IDX_FLAGS: rd_byte = {6'h00, irq_flags};
			`IDX_DEBUG: rd_byte = {7'h00, run_in_debug};
			`IDX_LATCH: rd_byte = byte_latch;
			`IDX_RESULT_LO: begin
				rd_byte = conversion_result[7:0];
				rd_high = conversion_result[15:8];
			end
			`IDX_LOW_THR_LO: begin
				rd_byte = low_threshold[7:0];
				rd_high = low_threshold[15:8];
			end
			`IDX_HIGH_THR_LO: begin
				rd_byte = high_threshold[7:0];
				rd_high = high_threshold[15:8];
			end
			`IDX_RESULT_HI, `IDX_LOW_THR_HI, `IDX_HIGH_THR_HI: rd_byte = byte_latch;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
			w_idx <= 6'h00;
			w_byte <= `RST_BYTE;
			w_lane0 <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			awready <= ~next_aw_full;
			wready <= ~next_w_full;
			arready <= ~next_r_busy;
			if (aw_take)
				w_idx <= awaddr[7:2];
			if (w_take) begin
				w_byte <= wdata[7:0];
				w_lane0 <= wstrb[0];
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= idx_known(w_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_byte};
				rresp <= idx_known(r_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (r_done)
				rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Converter clock and sequencer

	wire [7:0] div_mask = 8'(({1'b0, 8'h01} << (9'(clock_divider) + 9'h001)) - 9'h001);
	wire tick = &(div_cnt | ~div_mask);
	wire halted = debug_halt & ~run_in_debug;
	wire sw_go = wr_start & w_byte[0];
	wire ev_go = event_in & event_start_en & ~halted;
	wire go = enable & ~halted & (sw_go | ev_go | wake_measure);
	wire [8:0] init_len = startup_cycles(startup_wait);
	wire [7:0] sample_len = `BASE_SAMPLE_CYCLES + 8'(sample_extension) - 8'h01;
	wire [6:0] sample_total = 7'h01 << accumulation_count;
	wire [15:0] next_accum = accum + {6'h00, core_stat.data};
	wire last_sample = samples_left == 6'h00;
	wire conv_done = state == ST_CONVERT && core_stat.done && last_sample;
	wire adv = tick & ~halted;
	wire hw_step = state == ST_CONVERT && core_stat.done && delay_variation_en;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 8'h00;
			state <= ST_IDLE;
			wait_cnt <= 8'h00;
			accum <= `RST_WORD;
			samples_left <= 6'h00;
			start_busy <= 1'b0;
			need_init <= 1'b0;
			core_ctl <= '0;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			core_ctl.convert_start <= 1'b0;
			if (wr_control && w_byte[`POS_ENABLE] && !enable || wr_wake_ref || wake_measure)
				need_init <= 1'b1;
			if (!enable) begin
				state <= ST_IDLE;
				start_busy <= 1'b0;
				core_ctl.sample_closed <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						if (go) begin
							start_busy <= 1'b1;
							core_ctl.input_channel <= input_channel;
							accum <= `RST_WORD;
							samples_left <= 6'(sample_total - 7'h01);
							if ((need_init || wake_measure) && init_len != 9'h000) begin
								state <= ST_INIT;
								wait_cnt <= 8'(init_len - 9'h001);
							end else begin
								state <= ST_SAMPLE;
								wait_cnt <= sample_len;
								core_ctl.sample_closed <= 1'b1;
							end
							need_init <= 1'b0;
						end
					end
					ST_INIT: begin
						if (adv) begin
							if (wait_cnt == 8'h00) begin
								state <= ST_SAMPLE;
								wait_cnt <= sample_len;
								core_ctl.sample_closed <= 1'b1;
							end else
								wait_cnt <= wait_cnt - 8'h01;
						end
					end
					ST_SAMPLE: begin
						if (adv) begin
							if (wait_cnt == 8'h00) begin
								state <= ST_CONVERT;
								core_ctl.sample_closed <= 1'b0;
								core_ctl.convert_start <= 1'b1;
							end else
								wait_cnt <= wait_cnt - 8'h01;
						end
					end
					ST_CONVERT: begin
						if (core_stat.done) begin
							accum <= next_accum;
							if (last_sample) begin
								samples_left <= 6'(sample_total - 7'h01);
								core_ctl.input_channel <= input_channel;
								if (continuous_mode) begin
									state <= ST_SAMPLE;
									accum <= `RST_WORD;
									wait_cnt <= sample_len;
									core_ctl.sample_closed <= 1'b1;
								end else begin
									state <= ST_IDLE;
									start_busy <= 1'b0;
								end
							end else begin
								samples_left <= samples_left - 6'h01;
								if (intersample_delay != 4'h0) begin
									state <= ST_DELAY;
									wait_cnt <= 8'(intersample_delay) - 8'h01;
								end else begin
									state <= ST_SAMPLE;
									wait_cnt <= sample_len;
									core_ctl.sample_closed <= 1'b1;
								end
							end
						end
					end
					ST_DELAY: begin
						// Switch stays open here so no charge is taken between samples
						if (adv) begin
							if (wait_cnt == 8'h00) begin
								state <= ST_SAMPLE;
								wait_cnt <= sample_len;
								core_ctl.sample_closed <= 1'b1;
							end else
								wait_cnt <= wait_cnt - 8'h01;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers, flags and byte latch

	wire win_set = conv_done && window_hit(window_mode_sel, next_accum, low_threshold,
		high_threshold);
	wire [1:0] flag_set = {win_set, conv_done};
	wire [1:0] flag_clr = (wr_flags ? w_byte[1:0] : 2'h0) | {2{rd_result}};
	wire [1:0] next_flags = (irq_flags & ~flag_clr) | flag_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= 1'b0;
			continuous_mode <= 1'b0;
			refsel <= 2'h0;
			accumulation_count <= 3'h0;
			clock_divider <= 3'h0;
			startup_wait <= 3'h0;
			delay_variation_en <= 1'b0;
			intersample_delay <= 4'h0;
			window_mode_sel <= 3'h0;
			sample_extension <= 5'h00;
			input_channel <= 5'h00;
			event_start_en <= 1'b0;
			irq_enable <= 2'h0;
			irq_flags <= 2'h0;
			run_in_debug <= 1'b0;
			byte_latch <= `RST_BYTE;
			conversion_result <= `RST_WORD;
			low_threshold <= `RST_WORD;
			high_threshold <= `RST_WORD;
			irq <= 1'b0;
		end else begin
			irq_flags <= next_flags;
			irq <= |(next_flags & irq_enable);
			if (conv_done)
				conversion_result <= next_accum;
			if (rd_low_word)
				byte_latch <= rd_high;
			if (hw_step)
				intersample_delay <= intersample_delay + 4'h1;
			if (wr) begin
				case (w_idx)
					`IDX_CONTROL: begin
						enable <= w_byte[`POS_ENABLE];
						continuous_mode <= w_byte[`POS_CONTINUOUS];
					end
					`IDX_ACCUM: accumulation_count <= w_byte[2:0];
					`IDX_CLOCK: begin
						clock_divider <= w_byte[2:0];
						refsel <= w_byte[`POS_REFSEL +: 2];
					end
					`IDX_TIMING: begin
						// A software write wins over the automatic step in the same cycle
						startup_wait <= w_byte[`POS_STARTUP +: 3];
						delay_variation_en <= w_byte[`POS_VARIATION];
						intersample_delay <= w_byte[3:0];
					end
					`IDX_WINDOW: window_mode_sel <= w_byte[2:0];
					`IDX_SAMPLE_LEN: sample_extension <= w_byte[4:0];
					`IDX_INPUT_SEL: input_channel <= w_byte[4:0];
					`IDX_EVENT: event_start_en <= w_byte[0];
					`IDX_IRQ_EN: irq_enable <= w_byte[1:0];
					`IDX_DEBUG: run_in_debug <= w_byte[0];
					`IDX_LATCH, `IDX_LOW_THR_HI, `IDX_HIGH_THR_HI: byte_latch <= w_byte;
					`IDX_LOW_THR_LO: low_threshold <= {byte_latch, w_byte};
					`IDX_HIGH_THR_LO: high_threshold <= {byte_latch, w_byte};
					default: ;
				endcase
			end
		end
	end

endmodule

// >>> src/adc_seq_consts.svh
// Register offsets, field positions, reset values and timing figures of the converter sequencer
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Register indices; the byte address is four times the index
`define IDX_CONTROL 6'h00
`define IDX_ACCUM 6'h01
`define IDX_CLOCK 6'h02
`define IDX_TIMING 6'h03
`define IDX_WINDOW 6'h04
`define IDX_SAMPLE_LEN 6'h05
`define IDX_INPUT_SEL 6'h06
`define IDX_START 6'h08
`define IDX_EVENT 6'h09
`define IDX_IRQ_EN 6'h0a
`define IDX_FLAGS 6'h0b
`define IDX_DEBUG 6'h0c
`define IDX_LATCH 6'h0d
`define IDX_RESULT_LO 6'h10
`define IDX_RESULT_HI 6'h11
`define IDX_LOW_THR_LO 6'h12
`define IDX_LOW_THR_HI 6'h13
`define IDX_HIGH_THR_LO 6'h14
`define IDX_HIGH_THR_HI 6'h15

// Field positions
`define POS_ENABLE 0
`define POS_CONTINUOUS 1
`define POS_REFSEL 4
`define POS_STARTUP 5
`define POS_VARIATION 4
`define POS_RESULT_READY 0
`define POS_WINDOW_MATCH 1

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Reference code for the internal reference
`define REF_INTERNAL 2'h0

// Sampling phase before extension, in converter clock cycles
`define BASE_SAMPLE_CYCLES 8'h02

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> src/adc_seq_pkg.sv
// Types shared by the converter sequencer and its surroundings
package adc_seq_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INIT = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b011,
		ST_DELAY = 3'b100
	} seq_state_e;

	typedef enum logic [2:0] {
		WIN_NONE = 3'b000,
		WIN_BELOW = 3'b001,
		WIN_ABOVE = 3'b010,
		WIN_INSIDE = 3'b011,
		WIN_OUTSIDE = 3'b100
	} window_mode_e;

	// Requests to the analog core
	typedef struct packed {
		logic sample_closed;
		logic convert_start;
		logic [4:0] input_channel;
	} core_ctl_s;

	// Answers from the analog core
	typedef struct packed {
		logic done;
		logic [9:0] data;
	} core_stat_s;

endpackage

// >>> verif/analog_core_model.sv
// Behavioural analog core answering the sequencer's conversion requests
`timescale 1ns/1ns

module analog_core_model import adc_seq_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sequencer side
	input wire core_ctl_s core_ctl,
	output core_stat_s core_stat,
	// Answer delay in clocks, set by the bench
	input wire logic [3:0] latency
);
	logic busy;
	logic [3:0] cnt;
	logic [4:0] chan;

	// Data carries no meaning outside the done pulse, so it toggles to expose stale use
	always @(posedge aclk) begin
		core_stat.done <= 1'b0;
		core_stat.data <= ~core_stat.data;
		if (!aresetn) begin
			busy <= 1'b0;
			core_stat <= '0;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h0) begin
				busy <= 1'b0;
				core_stat.done <= 1'b1;
				core_stat.data <= {chan, 5'h03};
			end
		end else if (core_ctl.convert_start) begin
			busy <= 1'b1;
			cnt <= latency;
			chan <= core_ctl.input_channel;
		end
	end
endmodule

// >>> verif/adc_seq_chk_sva.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module adc_seq_chk import adc_seq_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Analog core
	input wire core_ctl_s core_ctl
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_bresp_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_slverr_zero: assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h0)
		else $error("error read carries data");
	a_byte_lane: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_start_pulse: assert property (core_ctl.convert_start |=> !core_ctl.convert_start)
		else $error("convert start too long");
	a_sample_min: assert property ($rose(core_ctl.sample_closed) |=> core_ctl.sample_closed [*2])
		else $error("sampling phase too short");
	a_chan_stable: assert property (core_ctl.sample_closed && $past(core_ctl.sample_closed)
		|-> $stable(core_ctl.input_channel))
		else $error("channel changed while sampling");
endmodule

bind adc_sequencing_control adc_seq_chk #(.ADDR_W(ADDR_W)) u_adc_seq_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .core_ctl(core_ctl)
);

// >>> verif/tb_top.sv
// Register-level bench for the converter sequencer
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module tb_top import adc_seq_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic event_in = 1'b0, debug_halt = 1'b0, wake_measure = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0, lat = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	core_ctl_s core_ctl;
	core_stat_s core_stat;
	logic [7:0] rd_val;
	logic [1:0] rd_resp;
	logic [5:0] map [10] = '{`IDX_TIMING, `IDX_WINDOW, `IDX_SAMPLE_LEN, `IDX_INPUT_SEL,
		`IDX_START, `IDX_EVENT, `IDX_IRQ_EN, `IDX_FLAGS, `IDX_DEBUG, `IDX_LATCH};
	int error_cnt = 0;
	int cmp_count = 0;

	adc_sequencing_control u_adc_sequencing_control (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .event_in(event_in), .debug_halt(debug_halt),
		.wake_measure(wake_measure), .core_ctl(core_ctl), .core_stat(core_stat), .irq(irq));
	analog_core_model u_analog_core_model (.aclk(aclk), .aresetn(aresetn),
		.core_ctl(core_ctl), .core_stat(core_stat), .latency(lat));

	initial begin
		forever #5 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !bvalid; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bvalid", 16'h1, {15'h0, bvalid});
		chk("bresp", {14'h0, er}, {14'h0, bresp});
		if (n == 40) end_sim;
	endtask

	task automatic rd(input logic [5:0] idx);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !rvalid; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		rd_val = rdata[7:0];
		rd_resp = rresp;
		if (n == 40) begin
			chk("rvalid", 16'h1, 16'h0);
			end_sim;
		end
	endtask

	task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input string nm);
		rd(idx);
		chk(nm, {8'h0, exp}, {8'h0, rd_val});
	endtask

	// Polls the flags; a conversion that never completes ends the run
	task automatic wait_ready(input logic [7:0] flags, input logic exp_irq,
		input logic [7:0] exp_start = 8'h00);
		int n;
		for (n = 0; n < 300; n++) begin
			rd(`IDX_FLAGS);
			if (rd_val[0] === 1'b1) break;
		end
		chk("flags", {8'h0, flags}, {8'h0, rd_val});
		chk("irq", {15'h0, exp_irq}, {15'h0, irq});
		rchk(`IDX_START, exp_start, "start after ready");
		if (n == 300) end_sim;
	endtask

	task automatic res_chk(input logic [15:0] exp);
		rchk(`IDX_RESULT_LO, exp[7:0], "result low");
		rchk(`IDX_RESULT_HI, exp[15:8], "result high");
		rchk(`IDX_FLAGS, 8'h00, "flags after result read");
	endtask

	task automatic pulse_event;
		@(posedge aclk);
		event_in <= 1'b1;
		@(posedge aclk);
		event_in <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rchk(map[i], 8'h00, "reset value");
		end
		rd(6'h07);
		chk("unmapped resp", {14'h0, `RESP_SLVERR}, {14'h0, rd_resp});
		chk("unmapped data", 16'h0, {8'h0, rd_val});
		wr(6'h0e, 8'h55, `RESP_SLVERR);
		wr(`IDX_LATCH, 8'h5a);
		rchk(`IDX_LATCH, 8'h5a, "latch");
		// Window 0x0100..0x0200; the low read must refresh the latch
		wr(`IDX_LOW_THR_HI, 8'h01);
		wr(`IDX_LOW_THR_LO, 8'h00);
		wr(`IDX_HIGH_THR_HI, 8'h02);
		wr(`IDX_HIGH_THR_LO, 8'h00);
		rchk(`IDX_LOW_THR_LO, 8'h00, "low threshold low");
		rchk(`IDX_LOW_THR_HI, 8'h01, "low threshold high");
		wr(`IDX_CONTROL, 8'h01);
		wr(`IDX_ACCUM, 8'h01);
		wr(`IDX_SAMPLE_LEN, 8'h03);
		wr(`IDX_INPUT_SEL, 8'h05);
		wr(`IDX_IRQ_EN, 8'h02);
		// Two samples of 0x0a3 accumulate to 0x0146, strictly inside the window
		for (int m = 0; m < 5; m++) begin
			wr(`IDX_WINDOW, 8'(m));
			wr(`IDX_START, 8'h01);
			rchk(`IDX_START, 8'h01, "start busy");
			wait_ready({6'h0, m == 3, 1'b1}, m == 3);
			res_chk(16'h0146);
		end
		// Inside mode again, so both flags are raised by the next conversion
		wr(`IDX_WINDOW, 8'h03);
		wr(`IDX_START, 8'h01);
		wr(`IDX_FLAGS, 8'h01);
		wait_ready(8'h03, 1'b1);
		wr(`IDX_FLAGS, 8'h00);
		rchk(`IDX_FLAGS, 8'h03, "flags zero write");
		wr(`IDX_FLAGS, 8'h01);
		rchk(`IDX_FLAGS, 8'h02, "flags one write");
		wr(`IDX_IRQ_EN, 8'h01);
		wr(`IDX_WINDOW, 8'h00);
		lat <= 4'h9;
		wr(`IDX_START, 8'h01);
		wr(`IDX_INPUT_SEL, 8'h06);
		wait_ready(8'h03, 1'b1);
		res_chk(16'h0146);
		pulse_event;
		rchk(`IDX_START, 8'h00, "event disabled");
		wr(`IDX_EVENT, 8'h01);
		debug_halt <= 1'b1;
		pulse_event;
		rchk(`IDX_START, 8'h00, "halted event");
		wr(`IDX_DEBUG, 8'h01);
		pulse_event;
		wait_ready(8'h01, 1'b1);
		res_chk(16'h0186);
		debug_halt <= 1'b0;
		wr(`IDX_TIMING, 8'h3f);
		@(posedge aclk);
		wake_measure <= 1'b1;
		@(posedge aclk);
		wake_measure <= 1'b0;
		// Without the startup wait the switch would already be closed here
		repeat (6) @(posedge aclk);
		chk("startup wait", 16'h0, {15'h0, core_ctl.sample_closed});
		chk("channel", 16'h6, {11'h0, core_ctl.input_channel});
		wait_ready(8'h01, 1'b1);
		rchk(`IDX_TIMING, 8'h31, "delay after wrap");
		wr(`IDX_CONTROL, 8'h03);
		wr(`IDX_START, 8'h01);
		wait_ready(8'h01, 1'b1, 8'h01);
		rchk(`IDX_START, 8'h01, "continuous busy");
		wr(`IDX_CONTROL, 8'h01);
		res_chk(16'h0186);
		end_sim;
	end
endmodule
